/* verilog/ext_indirect_access.v */
// How it works
// [RQ1] address function plus space, then window write loads the pointer
// [RQ2] address function: window reads return the pointer, repeatedly
// [RQ3] data function: window writes overwrite the pointed register each time
// [RQ4] data function: window reads return pointed register, pointer unchanged
// [RQ5] increment-all function: write stores then pointer advances by one
// [RQ6] increment-all function: read returns register then pointer advances
// [RQ7] write-only-increment function: write stores then pointer advances
// [RQ8] same sequences work for the pma space selector
// [RQ9] pointer is retained between operations, setup may be skipped
// [RQ10] address function: window writes replace pointer, no data touched
// [RQ11] control holds function in bits 15:14, space in bits 4:0
// [RQ12] window accesses with unsupported space are ignored
// [RQ13] write-only-increment function: reads leave pointer unchanged
// [RQ14] control at direct address 0x0D, window at 0x0E
// [RQ15] other control bits read zero and ignore writes
`default_nettype none
`include "ext_access_consts.vh"
module ext_indirect_access (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // direct register request from the frame decoder
    input wire req_valid,
    input wire req_write,
    input wire [4:0] req_addr,
    input wire [15:0] req_wdata,
    // answer
    output reg rsp_valid,
    output reg rsp_hit,
    output reg [15:0] rsp_rdata
);
    // ****************************************
    // state
    // ****************************************
    reg [1:0] func_q;
    reg [4:0] space_q;
    reg [15:0] ptr_main_q;
    reg [15:0] ptr_pma_q;
    reg [15:0] ptr_v3_q;
    reg [15:0] ptr_v7_q;
    reg [15:0] ptr_cur;
    reg [1:0] sidx;
    reg space_ok;
    wire [15:0] store_rdata;
    wire hit_ctrl;
    wire hit_win;
    wire win_acc;
    wire data_fn;
    wire inc_all;
    wire inc_wr;
    wire do_inc;
    wire [16:0] ptr_sum;
    wire [15:0] ptr_next;
    wire store_wr;
    reg rsp_valid_d;
    reg rsp_hit_d;
    reg [15:0] rsp_rdata_d;
    // whole control word at reset; only the function and space fields are kept
    localparam [15:0] CTRL_INIT = `CTRL_RST;

    // ****************************************
    // decode
    // ****************************************
    // [RQ14] direct address decode
    assign hit_ctrl = req_valid && (req_addr == `EXT_CTRL_ADDR);
    assign hit_win = req_valid && (req_addr == `EXT_WIN_ADDR);
    // [RQ12] unsupported space gates window access
    assign win_acc = hit_win && space_ok;
    assign data_fn = (func_q != `FUNC_ADDR);
    // [RQ5] [RQ6] increment-all moves on reads and writes
    assign inc_all = win_acc && (func_q == `FUNC_INC_ALL);
    // [RQ7] [RQ13] write-only increment ignores reads
    assign inc_wr = win_acc && (func_q == `FUNC_INC_WR) && req_write;
    assign do_inc = inc_all || inc_wr;
    // carry dropped on purpose: the pointer wraps at the top of its range
    assign ptr_sum = {1'b0, ptr_cur} + 17'h0_0001;
    assign ptr_next = ptr_sum[15:0];
    // [RQ3] data write to pointed register; [RQ10] never in address mode
    assign store_wr = win_acc && req_write && data_fn;

    // space selector map, one pointer per space
    always @*
    begin
        sidx = `SIDX_MAIN;
        space_ok = 1'b1;
        ptr_cur = ptr_main_q;
        // [RQ8] pma and vendor spaces share the sequences
        // unsupported selectors fall back to the main pointer, but every write and increment is gated off
        case (space_q)
            `SPACE_MAIN:
            begin
                sidx = `SIDX_MAIN;
                ptr_cur = ptr_main_q;
            end
            `SPACE_PMA:
            begin
                sidx = `SIDX_PMA;
                ptr_cur = ptr_pma_q;
            end
            `SPACE_V3:
            begin
                sidx = `SIDX_V3;
                ptr_cur = ptr_v3_q;
            end
            `SPACE_V7:
            begin
                sidx = `SIDX_V7;
                ptr_cur = ptr_v7_q;
            end
            default:
            begin
                space_ok = 1'b0;
            end
        endcase
    end

    // ****************************************
    // control register
    // ****************************************
    // [RQ11] [RQ15] only function and space bits are stored
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            func_q <= CTRL_INIT[`FUNC_HI:`FUNC_LO];
            space_q <= CTRL_INIT[`SPACE_HI:`SPACE_LO];
        end
        else if (hit_ctrl && req_write)
        begin
            func_q <= req_wdata[`FUNC_HI:`FUNC_LO];
            space_q <= req_wdata[`SPACE_HI:`SPACE_LO];
        end
    end

    // ****************************************
    // pointers, kept per space so a space switch keeps them
    // ****************************************
    // [RQ9] pointers only change on window access
    // a control write never clears a pointer, so the setup writes may be skipped later
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ptr_main_q <= `PTR_RST;
            ptr_pma_q <= `PTR_RST;
            ptr_v3_q <= `PTR_RST;
            ptr_v7_q <= `PTR_RST;
        end
        // [RQ1] [RQ10] address mode write loads pointer
        else if (win_acc && req_write && !data_fn)
        begin
            case (sidx)
                `SIDX_MAIN: ptr_main_q <= req_wdata;
                `SIDX_PMA: ptr_pma_q <= req_wdata;
                `SIDX_V3: ptr_v3_q <= req_wdata;
                `SIDX_V7: ptr_v7_q <= req_wdata;
                default: ptr_main_q <= ptr_main_q;
            endcase
        end
        // [RQ5] post increment after the access
        else if (do_inc)
        begin
            case (sidx)
                `SIDX_MAIN: ptr_main_q <= ptr_next;
                `SIDX_PMA: ptr_pma_q <= ptr_next;
                `SIDX_V3: ptr_v3_q <= ptr_next;
                `SIDX_V7: ptr_v7_q <= ptr_next;
                default: ptr_main_q <= ptr_main_q;
            endcase
        end
    end

    // one store for all spaces; read and write share the pointed address
    ext_space_store u_store (
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_en(store_wr),
        .wr_space(sidx),
        .wr_addr(ptr_cur),
        .wr_data(req_wdata),
        .rd_space(sidx),
        .rd_addr(ptr_cur),
        .rd_data(store_rdata)
    );

    // ****************************************
    // answer selection
    // ****************************************
    // read data is picked before the post increment lands, so a read sees the old pointer
    always @*
    begin
        rsp_valid_d = req_valid;
        rsp_hit_d = hit_ctrl || win_acc;
        rsp_rdata_d = 16'h0000;
        if (hit_ctrl)
            // [RQ15] reserved bits read zero
            rsp_rdata_d = {func_q, 9'h000, space_q};
        else if (win_acc && !data_fn)
            // [RQ2] address mode reads pointer
            rsp_rdata_d = ptr_cur;
        else if (win_acc)
            // [RQ4] [RQ6] [RQ13] pointed register
            rsp_rdata_d = store_rdata;
    end

    // ****************************************
    // answer, one cycle after the request
    // ****************************************
    // registered so the frame decoder only ever sees a settled word
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rsp_valid <= 1'b0;
            rsp_hit <= 1'b0;
            rsp_rdata <= 16'h0000;
        end
        else
        begin
            rsp_valid <= rsp_valid_d;
            rsp_hit <= rsp_hit_d;
            rsp_rdata <= rsp_rdata_d;
        end
    end
endmodule // ext_indirect_access
`default_nettype wire

/* verilog/ext_access_consts.vh */
`ifndef EXT_ACCESS_CONSTS_VH
`define EXT_ACCESS_CONSTS_VH
// direct management addresses
`define EXT_CTRL_ADDR 5'h0D
`define EXT_WIN_ADDR 5'h0E
// control field positions
`define FUNC_HI 15
`define FUNC_LO 14
`define SPACE_HI 4
`define SPACE_LO 0
// function codes
`define FUNC_ADDR 2'h0
`define FUNC_DATA 2'h1
`define FUNC_INC_ALL 2'h2
`define FUNC_INC_WR 2'h3
// target space selectors
`define SPACE_MAIN 5'h1F
`define SPACE_PMA 5'h01
`define SPACE_V3 5'h03
`define SPACE_V7 5'h07
// space index codes
`define SIDX_MAIN 2'h0
`define SIDX_PMA 2'h1
`define SIDX_V3 2'h2
`define SIDX_V7 2'h3
// reset values
`define CTRL_RST 16'h0000
`define PTR_RST 16'h0000
`define DATA_RST 16'h0000
// storage depth per space, in address bits
`define EXT_AW 6
`endif

/* verilog/ext_space_store.v */
`default_nettype none
`include "ext_access_consts.vh"
// ****************************************
// extended register storage, one array for all spaces
// ****************************************
module ext_space_store (
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // write side
    input wire wr_en,
    input wire [1:0] wr_space,
    input wire [15:0] wr_addr,
    input wire [15:0] wr_data,
    // read side, combinational
    input wire [1:0] rd_space,
    input wire [15:0] rd_addr,
    output wire [15:0] rd_data
);
    localparam DEPTH = 4 << `EXT_AW;
    reg [15:0] mem_q [0:DEPTH-1];
    wire [`EXT_AW+1:0] wr_idx;
    wire [`EXT_AW+1:0] rd_idx;
    genvar i;
    // pointer upper bits wrap inside the small store; real maps would decode them
    assign wr_idx = {wr_space, wr_addr[`EXT_AW-1:0]};
    assign rd_idx = {rd_space, rd_addr[`EXT_AW-1:0]};
    assign rd_data = mem_q[rd_idx];
    // one flop row per entry
    generate
        for (i = 0; i < DEPTH; i = i + 1)
        begin : g_ent
            always @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                    mem_q[i] <= `DATA_RST;
                else if (wr_en && (wr_idx == i))
                    mem_q[i] <= wr_data;
            end
        end
    endgenerate
endmodule // ext_space_store
`default_nettype wire

/* verification/ext_access_properties.sv */
`default_nettype none
// ****
// answer checks
// ****
module ext_access_properties (
    // clock, reset
    input wire logic ref_clk,
    input wire logic rst,
    // request, answer
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [4:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic rsp_valid,
    input wire logic rsp_hit,
    input wire logic [15:0] rsp_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] ctl_q;
    logic win;
    logic ok;
    // window strobe and supported-space decode
    assign win = req_valid && req_addr == 5'h0E;
    assign ok = ctl_q[4:0] inside {5'h1F, 5'h01, 5'h03, 5'h07};
    // shadow of function and space, so the echo checks know the mode
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            ctl_q <= 7'h00;
        else if (req_valid && req_write && req_addr == 5'h0D)
            ctl_q <= {req_wdata[15:14], req_wdata[4:0]};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    rsp_pulse_a: assert property (req_valid |=> rsp_valid)
        else $error("no answer");
    ctrl_hit_a: assert property (req_valid && req_addr == 5'h0D |=> rsp_hit)
        else $error("control missed");
    ctrl_zero_a: assert property (win == 1'b0 && req_valid && !req_write && req_addr == 5'h0D
        |=> rsp_rdata[13:5] == 9'h000) else $error("control spare bits set");
    stray_addr_a: assert property (req_valid && req_addr < 5'h0D |=> !rsp_hit && rsp_rdata == 16'h0000)
        else $error("stray address answered");
    bad_space_a: assert property (win && !ok |=> !rsp_hit && rsp_rdata == 16'h0000)
        else $error("bad space answered");
    good_space_a: assert property (win && ok |=> rsp_hit)
        else $error("good space refused");
    addr_echo_a: assert property (win && req_write && ok && ctl_q[6:5] == 2'h0 ##1 !req_valid
        ##1 win && !req_write |=> rsp_rdata == $past(req_wdata, 3)) else $error("pointer not echoed");
    data_echo_a: assert property (win && req_write && ok && ctl_q[6:5] == 2'h1 ##1 !req_valid
        ##1 win && !req_write |=> rsp_rdata == $past(req_wdata, 3)) else $error("data not kept");
endmodule // ext_access_properties
bind ext_indirect_access ext_access_properties u_props (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_hit(rsp_hit),
    .rsp_rdata(rsp_rdata));
`default_nettype wire

/* verification/mgmt_station.sv */
`default_nettype none
// ****
// station model
// ****
module mgmt_station (
    // clock
    input wire logic ref_clk,
    // request, answer
    output var logic req_valid = 1'b0,
    output var logic req_write = 1'b0,
    output var logic [4:0] req_addr = 5'h00,
    output var logic [15:0] req_wdata = 16'h0000,
    input wire logic rsp_valid,
    input wire logic rsp_hit,
    input wire logic [15:0] rsp_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // held across the taking edge, answer taken one cycle on
    task automatic access(input logic w, input logic [4:0] a, input logic [15:0] d,
        output logic v, output logic h, output logic [15:0] q);
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        @(negedge ref_clk);
        v = rsp_valid;
        h = rsp_hit;
        q = rsp_rdata;
        // released lines show the inverse, so stale data never looks current
        req_valid = 1'b0;
        req_addr = ~a;
        req_wdata = ~d;
    endtask
endmodule // mgmt_station
`default_nettype wire

/* verification/tb_top.sv */
`default_nettype none
// ****
// indirect access bench
// ****
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [4:0] CTL = 5'h0D;
    localparam logic [4:0] WIN = 5'h0E;
    localparam logic [4:0] SP [4] = '{5'h1F, 5'h01, 5'h03, 5'h07};
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid, req_write, rsp_valid, rsp_hit, v, h;
    logic [4:0] req_addr;
    logic [4:0] sp_q = 5'h00;
    logic [15:0] req_wdata, rsp_rdata, q;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;
    ext_indirect_access u_dut (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_hit(rsp_hit), .rsp_rdata(rsp_rdata));
    mgmt_station u_sta (.ref_clk(ref_clk), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_hit(rsp_hit), .rsp_rdata(rsp_rdata));
    // free-running clock
    initial
        forever #5 ref_clk = ~ref_clk;
    // compare and count; an unknown never matches
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one access; the space is tracked here to predict the hit flag
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
        if (w && a == CTL)
            sp_q = d[4:0];
        u_sta.access(w, a, d, v, h, q);
        chk({15'h0000, v}, 16'h0001);
        chk({15'h0000, h}, {15'h0000, a == CTL || a == WIN && sp_q inside {SP}});
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        acc(1'b0, a, 16'h0000);
        chk(q, e);
    endtask
    // address mode, with control spare bits written as ones
    task automatic t_addr();
        wr(CTL, 16'hFFFF);
        rd(CTL, 16'hC01F);
        wr(CTL, 16'h001F);
        wr(WIN, 16'h0005);
        wr(WIN, 16'h0009);
        rd(WIN, 16'h0009);
        rd(WIN, 16'h0009);
    endtask
    // data mode overwrites one place; pointer survives for later setup-free use
    task automatic t_data();
        wr(CTL, 16'h401F);
        wr(WIN, 16'h1111);
        wr(WIN, 16'hABCD);
        rd(WIN, 16'hABCD);
        rd(WIN, 16'hABCD);
        wr(CTL, 16'h001F);
        rd(WIN, 16'h0009);
    endtask
    // both increment modes: only the write-only mode leaves reads in place
    task automatic t_inc();
        wr(CTL, 16'h801F);
        for (int i = 0; i < 3; i++)
            wr(WIN, 16'h0100 + 16'(i));
        wr(CTL, 16'h001F);
        rd(WIN, 16'h000C);
        wr(WIN, 16'h0009);
        wr(CTL, 16'h801F);
        for (int i = 0; i < 3; i++)
            rd(WIN, 16'h0100 + 16'(i));
        wr(CTL, 16'h001F);
        wr(WIN, 16'h000A);
        wr(CTL, 16'hC01F);
        rd(WIN, 16'h0101);
        wr(WIN, 16'h0300);
        rd(WIN, 16'h0102);
        // the write under write-only increment must have landed at the old pointer
        wr(CTL, 16'h001F);
        wr(WIN, 16'h000A);
        wr(CTL, 16'h401F);
        rd(WIN, 16'h0300);
    endtask
    // every supported space holds its own data; others are refused
    task automatic t_space();
        for (int i = 0; i < 8; i++)
        begin
            wr(CTL, {11'h000, SP[i % 4]});
            if (i < 4)
                wr(WIN, 16'h0020);
            wr(CTL, {11'h200, SP[i % 4]});
            acc(i < 4, WIN, {11'h280, SP[i % 4]});
            if (i >= 4)
                chk(q, {11'h280, SP[i % 4]});
        end
        // pma increment walks its own pointer
        wr(CTL, 16'h8001);
        rd(WIN, 16'h5001);
        wr(CTL, 16'h0001);
        rd(WIN, 16'h0021);
        wr(CTL, 16'h4002);
        wr(WIN, 16'h7777);
        rd(WIN, 16'h0000);
        // the refused write must not have reached the main space
        wr(CTL, 16'h401F);
        rd(WIN, 16'h501F);
        rd(5'h00, 16'h0000);
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // reset for two cycles, then the scenarios
    initial
    begin
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        t_addr();
        t_data();
        t_inc();
        t_space();
        print_verdict();
    end
    // a hang counts as a mismatch
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            error_cnt++;
            print_verdict();
        end
    end
endmodule // tb_top
`default_nettype wire
